// ===== src/spm_defines.svh
// constants shared by the serial master block
`ifndef SPM_DEFINES_SVH
`define SPM_DEFINES_SVH

// core clock
`define SPM_CLK_PERIOD_NS 5
// flash link clock: legal period window and the chosen period
`define SPM_FLASH_MIN_NS 20
`define SPM_FLASH_MAX_NS 100
`define SPM_FLASH_SCK_NS 40
// power link clock: chosen period (legal 33.3 ns .. 100 ns)
`define SPM_PWR_SCK_NS 50
// half periods in core cycles, rounded down, so the rate never falls below the chosen rate
`define SPM_FLASH_HALF ((`SPM_FLASH_SCK_NS / `SPM_CLK_PERIOD_NS) / 2)
`define SPM_PWR_HALF ((`SPM_PWR_SCK_NS / `SPM_CLK_PERIOD_NS) / 2)
// data layout
`define SPM_BYTE_W 8
`define SPM_QUAD_W 4
`define SPM_CNT_W 4
`define SPM_BITS_SINGLE 4'h8
`define SPM_BITS_QUAD 4'h2
`define SPM_MISO_LINE 1
`define SPM_MOSI_LINE 0
`define SPM_ENTRY_W 9
`define SPM_BUF_DEPTH 2
`define SPM_LINK_FLASH 1'b0
`define SPM_LINK_PWR 1'b1

`endif

// ===== src/spm_pkg.sv
// types of the serial master block
`default_nettype none
`include "spm_defines.svh"
package spm_pkg;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_LOW,
        ST_HIGH,
        ST_DRAIN,
        ST_PUSH,
        ST_NEXT
    } spm_state_t;

    typedef struct packed {
        spm_state_t st;
        logic link;
        logic quad;
        logic qin;
        logic last;
        logic [`SPM_BYTE_W-1:0] tx;
        logic [`SPM_BYTE_W-1:0] rx;
        logic [`SPM_CNT_W-1:0] bits;
        logic [`SPM_CNT_W-1:0] cnt;
        logic [1:0] fpipe;
        logic [`SPM_QUAD_W-1:0] fsync1;
        logic [`SPM_QUAD_W-1:0] fsync2;
        logic psync1;
        logic psync2;
        logic fclk;
        logic fsel_n;
        logic [`SPM_QUAD_W-1:0] fout;
        logic [`SPM_QUAD_W-1:0] foe;
        logic pclk;
        logic psel_n;
        logic pout;
        logic cmd_rdy;
        logic busy;
        logic push;
        logic [`SPM_ENTRY_W-1:0] push_data;
    } spm_core_t;

    typedef struct packed {
        logic [`SPM_BUF_DEPTH-1:0][`SPM_ENTRY_W-1:0] slot;
        logic [1:0] cnt;
    } spm_buf_t;

endpackage
`default_nettype wire

// ===== src/spm_stream_if.sv
// valid/ready stream carrying one received byte and its last flag
`timescale 1ns/100ps
`default_nettype none
`include "spm_defines.svh"
interface spm_stream_if;
    logic valid;
    logic ready;
    logic [`SPM_ENTRY_W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// ===== src/spm_rxbuf.sv
// two-entry receive buffer between the shift engine and the user
`timescale 1ns/100ps
`default_nettype none
`include "spm_defines.svh"
module spm_rxbuf
    import spm_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // streams
    spm_stream_if.snk wr,
    spm_stream_if.src rd
);
    spm_buf_t st_reg;
    spm_buf_t st_next;
    logic push;
    logic pop;

    ////////////////////////////////////////////////////////////////////////
    // fill level kept as a thermometer so valid leaves straight from a flop
    assign wr.ready = !st_reg.cnt[1];
    assign rd.valid = st_reg.cnt[0];
    assign rd.data = st_reg.slot[0];
    assign push = wr.valid && wr.ready;
    assign pop = rd.valid && rd.ready;

    // head always sits in slot 0, so the output is a plain flop
    always_comb begin
        st_next = st_reg;
        if (pop) begin
            st_next.slot[0] = st_reg.slot[1];
            st_next.cnt = {1'b0, st_reg.cnt[1]};
        end
        if (push) begin
            st_next.slot[st_next.cnt[0]] = wr.data;
            st_next.cnt = {st_next.cnt[0], 1'b1};
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end
endmodule
`default_nettype wire

// ===== src/spm_master.sv
// two-link late-capture serial master: flash port and power chip port
// Function
// - flash clock period within 20..100 ns
// - flash top rate may sit below ceiling
// - flash link mode 0, clock idles low
// - flash data launched on clock/select fall
// - flash lines sampled on falling edge
// - power link mode 0, clock idles low
// - power output launched on falling edges
// - power input sampled on falling edge
`timescale 1ns/100ps
`default_nettype none
`include "spm_defines.svh"
module spm_master
    import spm_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // command bytes
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic cmd_link,
    input wire logic cmd_quad,
    input wire logic cmd_qin,
    input wire logic cmd_last,
    input wire logic [`SPM_BYTE_W-1:0] cmd_data,
    // received bytes
    output logic rx_valid,
    input wire logic rx_ready,
    output logic [`SPM_BYTE_W-1:0] rx_data,
    output logic rx_last,
    output logic busy,
    // flash link
    output logic flash_serial_clock,
    output logic flash_select_n,
    input wire logic [`SPM_QUAD_W-1:0] flash_data_lines_in,
    output logic [`SPM_QUAD_W-1:0] flash_data_lines_out,
    output logic [`SPM_QUAD_W-1:0] flash_data_lines_oe,
    // power chip link
    output logic pwr_serial_clock,
    output logic pwr_select0_n,
    output logic pwr_serial_out,
    input wire logic pwr_serial_in
);
    localparam spm_core_t CORE_RST = '{st: ST_IDLE, fsel_n: 1'b1, psel_n: 1'b1, default: '0};

    spm_core_t st_reg;
    spm_core_t st_next;
    spm_stream_if rxq_in();
    spm_stream_if rxq_out();

    ////////////////////////////////////////////////////////////////////////
    // half period minus one per link, rounded down
    function automatic logic [`SPM_CNT_W-1:0] half_m1(input logic link);
        if (link == `SPM_LINK_PWR) begin
            half_m1 = `SPM_CNT_W'(`SPM_PWR_HALF - 1);
        end else begin
            half_m1 = `SPM_CNT_W'(`SPM_FLASH_HALF - 1);
        end
    endfunction

    // put the next bit or nibble on the lines and shift it out of tx
    function automatic spm_core_t launch(input spm_core_t c);
        spm_core_t r;
        r = c;
        if (c.link == `SPM_LINK_PWR) begin
            r.pout = c.tx[`SPM_BYTE_W-1];
            r.tx = {c.tx[`SPM_BYTE_W-2:0], 1'b0};
        end else if (c.quad) begin
            r.fout = c.tx[`SPM_BYTE_W-1 -: `SPM_QUAD_W];
            r.foe = c.qin ? '0 : '1;
            r.tx = {c.tx[`SPM_QUAD_W-1:0], `SPM_QUAD_W'(0)};
        end else begin
            r.fout = '0;
            r.fout[`SPM_MOSI_LINE] = c.tx[`SPM_BYTE_W-1];
            r.foe = '0;
            r.foe[`SPM_MOSI_LINE] = 1'b1;
            r.tx = {c.tx[`SPM_BYTE_W-2:0], 1'b0};
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    spm_rxbuf u_rxbuf (
        .clk(clk),
        .nrst(nrst),
        .wr(rxq_in.snk),
        .rd(rxq_out.src)
    );

    assign rxq_in.valid = st_reg.push;
    assign rxq_in.data = st_reg.push_data;
    assign rxq_out.ready = rx_ready;
    assign rx_valid = rxq_out.valid;
    assign rx_data = rxq_out.data[`SPM_BYTE_W-1:0];
    assign rx_last = rxq_out.data[`SPM_BYTE_W];

    assign cmd_ready = st_reg.cmd_rdy;
    assign busy = st_reg.busy;
    assign flash_serial_clock = st_reg.fclk;
    assign flash_select_n = st_reg.fsel_n;
    assign flash_data_lines_out = st_reg.fout;
    assign flash_data_lines_oe = st_reg.foe;
    assign pwr_serial_clock = st_reg.pclk;
    assign pwr_select0_n = st_reg.psel_n;
    assign pwr_serial_out = st_reg.pout;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        st_next = st_reg;
        // pins pass two flops; the fall strobe is delayed to match
        st_next.fsync1 = flash_data_lines_in;
        st_next.fsync2 = st_reg.fsync1;
        st_next.psync1 = pwr_serial_in;
        st_next.psync2 = st_reg.psync1;
        st_next.fpipe = {st_reg.fpipe[0], 1'b0};
        // late capture of the falling-edge sample
        if (st_reg.fpipe[1]) begin
            if (st_reg.link == `SPM_LINK_PWR) begin
                st_next.rx = {st_reg.rx[`SPM_BYTE_W-2:0], st_reg.psync2};
            end else if (st_reg.quad) begin
                st_next.rx = {st_reg.rx[`SPM_QUAD_W-1:0], st_reg.fsync2};
            end else begin
                st_next.rx = {st_reg.rx[`SPM_BYTE_W-2:0], st_reg.fsync2[`SPM_MISO_LINE]};
            end
        end
        if (st_reg.push && rxq_in.ready) begin
            st_next.push = 1'b0;
        end
        case (st_reg.st)
            ST_IDLE, ST_NEXT: begin
                st_next.cmd_rdy = 1'b1;
                if (cmd_valid && st_reg.cmd_rdy) begin
                    st_next.cmd_rdy = 1'b0;
                    if (st_reg.st == ST_IDLE) begin
                        st_next.link = cmd_link;
                        st_next.busy = 1'b1;
                        // select falls with the first bit
                        st_next.fsel_n = (cmd_link != `SPM_LINK_FLASH);
                        st_next.psel_n = (cmd_link != `SPM_LINK_PWR);
                    end
                    st_next.quad = cmd_quad && (st_next.link == `SPM_LINK_FLASH);
                    st_next.qin = cmd_qin;
                    st_next.last = cmd_last;
                    st_next.tx = cmd_data;
                    st_next.bits = st_next.quad ? `SPM_BITS_QUAD : `SPM_BITS_SINGLE;
                    st_next = launch(st_next);
                    st_next.cnt = half_m1(st_next.link);
                    st_next.st = ST_LOW;
                end
            end
            ST_LOW: begin
                if (st_reg.cnt == '0) begin
                    st_next.fclk = (st_reg.link == `SPM_LINK_FLASH);
                    st_next.pclk = (st_reg.link == `SPM_LINK_PWR);
                    st_next.cnt = half_m1(st_reg.link);
                    st_next.st = ST_HIGH;
                end else begin
                    st_next.cnt = st_reg.cnt - `SPM_CNT_W'(1);
                end
            end
            ST_HIGH: begin
                if (st_reg.cnt == '0) begin
                    // clock returns low on the fall edge
                    st_next.fclk = 1'b0;
                    st_next.pclk = 1'b0;
                    st_next.fpipe[0] = 1'b1;
                    st_next.bits = st_reg.bits - `SPM_CNT_W'(1);
                    if (st_next.bits != '0) begin
                        // next bit leaves on the sampling edge
                        st_next = launch(st_next);
                        st_next.cnt = half_m1(st_reg.link);
                        st_next.st = ST_LOW;
                    end else begin
                        st_next.st = ST_DRAIN;
                    end
                end else begin
                    st_next.cnt = st_reg.cnt - `SPM_CNT_W'(1);
                end
            end
            ST_DRAIN: begin
                // wait until the final sample is in
                if (st_reg.fpipe == '0) begin
                    st_next.push = 1'b1;
                    st_next.push_data = {st_reg.last, st_reg.rx};
                    st_next.st = ST_PUSH;
                end
            end
            ST_PUSH: begin
                // a full buffer stalls here with the clock parked low
                if (st_reg.push && rxq_in.ready) begin
                    if (st_reg.last) begin
                        // release select only after the capture
                        st_next.fsel_n = 1'b1;
                        st_next.psel_n = 1'b1;
                        st_next.foe = '0;
                        st_next.busy = 1'b0;
                        st_next.st = ST_IDLE;
                    end else begin
                        st_next.st = ST_NEXT;
                    end
                end
            end
            default: begin
                st_next = CORE_RST;
            end
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_reg <= CORE_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    // flash high phase is a fixed 20 ns
    AST_FLASH_HIGH: assert property ($rose(flash_serial_clock) |->
        flash_serial_clock[*4] ##1 !flash_serial_clock)
        else $error("flash clock high phase wrong");
    // low phase never shorter, so period is at least 40 ns
    AST_FLASH_RATE: assert property ($fell(flash_serial_clock) |->
        (!flash_serial_clock)[*4])
        else $error("flash clock low phase too short");
    // clock idle low outside a frame
    AST_FLASH_IDLE: assert property (flash_select_n |-> !flash_serial_clock)
        else $error("flash clock not idle low");
    // data only moves while the clock is low
    AST_FLASH_LAUNCH: assert property ($changed(flash_data_lines_out) |->
        !flash_serial_clock)
        else $error("flash data changed while clock high");
    // capture follows each fall after the synchroniser delay
    AST_FLASH_SAMPLE: assert property ($fell(flash_serial_clock) |-> ##1 st_reg.fpipe[1])
        else $error("flash sample not taken");
    AST_PWR_IDLE: assert property (pwr_select0_n |-> !pwr_serial_clock)
        else $error("power clock not idle low");
    // power output only moves while its clock is low
    AST_PWR_LAUNCH: assert property ($changed(pwr_serial_out) |-> !pwr_serial_clock)
        else $error("power data changed while clock high");
    AST_PWR_SAMPLE: assert property ($fell(pwr_serial_clock) |->
        ##1 (st_reg.fpipe[1] && st_reg.link))
        else $error("power sample not taken");
    // select rises only after the byte has been handed over
    AST_SEL_RELEASE: assert property (($rose(flash_select_n) || $rose(pwr_select0_n)) |->
        ($past(st_reg.st) == ST_PUSH) && $past(st_reg.fpipe, 2) == '0)
        else $error("select released before final capture");

    COV_FLASH: cover property ($rose(flash_select_n));
    COV_QUAD_RD: cover property (st_reg.quad && st_reg.qin && $fell(flash_serial_clock));
    COV_PWR: cover property ($rose(pwr_select0_n));
    COV_STALL: cover property (rxq_in.valid && !rxq_in.ready);
endmodule
`default_nettype wire

// ===== tb/spm_far_end.sv
// far-end serial device model answering resp plus byte index
`timescale 1ns/100ps
`default_nettype none
module spm_far_end (
    // link pins
    input wire logic sck,
    input wire logic sel_n,
    input wire logic [3:0] mosi,
    output logic [3:0] miso,
    // scenario control
    input wire logic quad,
    input wire logic [7:0] resp,
    output logic [7:0] got,
    output int falls
);
    logic [7:0] sh;
    logic [7:0] idx;
    int n;
    task automatic put(input logic inv);
        miso = quad ? sh[7:4] : {4{sh[7]}};
        if (inv)
            miso = ~miso;
    endtask
    initial begin
        miso = 4'h0;
        got = 8'h00;
        falls = 0;
    end
    always @(negedge sel_n) begin
        idx = 8'h00;
        n = 0;
        falls = 0;
        sh = resp;
        put(1'b0);
    end
    // released line shows no stale value
    always @(posedge sel_n) begin
        #2;
        miso = ~miso;
    end
    // answer valid only late in the high half, as late as setup allows
    always @(posedge sck) if (!sel_n) begin
        got = quad ? {got[3:0], mosi} : {got[6:0], mosi[0]};
        put(1'b1);
        #10;
        put(1'b0);
    end
    always @(negedge sck) if (!sel_n) begin
        #2;
        falls++;
        n++;
        sh = quad ? sh << 4 : sh << 1;
        if (n == (quad ? 2 : 8)) begin
            n = 0;
            idx++;
            sh = resp + idx;
        end
        put(1'b0);
    end
endmodule
`default_nettype wire

// ===== tb/test_spm_master_late_capture.sv
// self-checking bench of the two-link serial master
`timescale 1ns/100ps
`default_nettype none
module test_spm_master_late_capture;
    logic clk, nrst, cmd_valid, cmd_ready, cmd_link, cmd_quad, cmd_qin, cmd_last;
    logic rx_valid, rx_ready, rx_last, busy, fclk, fsel_n, pclk, psel_n, pout, prev_p;
    logic [7:0] cmd_data, rx_data, f_resp, p_resp, f_got, p_got;
    logic [3:0] f_in, f_out, f_oe, f_miso, p_miso, prev_f, oe_or;
    int f_falls, p_falls, miscompares, checks_done, edge_bad, idle_bad;
    real t0, per;
    logic [8:0] rxq[$];
    spm_master spm_master_i (.clk(clk), .nrst(nrst), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .cmd_link(cmd_link), .cmd_quad(cmd_quad), .cmd_qin(cmd_qin),
        .cmd_last(cmd_last), .cmd_data(cmd_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
        .rx_data(rx_data), .rx_last(rx_last), .busy(busy), .flash_serial_clock(fclk),
        .flash_select_n(fsel_n), .flash_data_lines_in(f_in), .flash_data_lines_out(f_out),
        .flash_data_lines_oe(f_oe), .pwr_serial_clock(pclk), .pwr_select0_n(psel_n),
        .pwr_serial_out(pout), .pwr_serial_in(p_miso[0]));
    spm_far_end flash_far_i (.sck(fclk), .sel_n(fsel_n), .mosi(f_out), .miso(f_miso),
        .quad(cmd_quad), .resp(f_resp), .got(f_got), .falls(f_falls));
    spm_far_end pwr_far_i (.sck(pclk), .sel_n(psel_n), .mosi({3'b000, pout}), .miso(p_miso),
        .quad(1'b0), .resp(p_resp), .got(p_got), .falls(p_falls));
    // wire level from the master's enables; the far end drives every line they leave off
    assign f_in = (f_oe & f_out) | (~f_oe & f_miso);
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // settled values at the falling core edge equal what the next rising edge samples
    always @(negedge clk) begin
        if (nrst && ((fsel_n && fclk) || (psel_n && pclk)))
            idle_bad++;
        if (!fsel_n && f_out !== prev_f && fclk)
            edge_bad++;
        if (!psel_n && pout !== prev_p && pclk)
            edge_bad++;
        // gathered outside flash frames too, so a power frame driving the lines shows
        oe_or = oe_or | f_oe;
        prev_f = f_out;
        prev_p = pout;
        if (nrst && rx_valid && rx_ready)
            rxq.push_back({rx_last, rx_data});
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic send(input logic link, quad, qin, last, input logic [7:0] d);
        int i;
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_link <= link;
        cmd_quad <= quad;
        cmd_qin <= qin;
        cmd_last <= last;
        cmd_data <= d;
        i = 0;
        do begin
            @(negedge clk);
            i++;
        end while (cmd_ready !== 1'b1 && i < 2000);
        @(posedge clk);
        cmd_valid <= 1'b0;
    endtask
    task automatic frame(input logic link, quad, qin, input int n, input logic [7:0] base);
        int i;
        rxq.delete();
        oe_or = 4'h0;
        for (i = 0; i < n; i++) begin
            send(link, quad, qin, i == n - 1, base + 8'(i));
        end
        i = 0;
        while ((rxq.size() < n || busy !== 1'b0) && i < 2000) begin
            @(negedge clk);
            i++;
        end
        check("frame_done", i < 2000, 1);
    endtask
    task automatic expect_rx(input int n, input logic [7:0] resp);
        for (int i = 0; i < n; i++) begin
            check("rx_entry", rxq[i], {i == n - 1, resp + 8'(i)});
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        repeat (3) @(negedge clk);
        check("reset_pins", {fclk, fsel_n, pclk, psel_n, f_oe}, 8'h50);
        check("reset_flags", {cmd_ready, rx_valid, busy}, 0);
        @(posedge clk);
        nrst <= 1'b1;
        rx_ready <= 1'b1;
        repeat (3) @(negedge clk);
        check("ready_after_reset", cmd_ready, 1);
    endtask
    task automatic t_flash();
        f_resp = 8'h5a;
        fork
            frame(1'b0, 1'b0, 1'b0, 3, 8'ha5);
            begin
                @(posedge fclk);
                t0 = $realtime;
                @(posedge fclk);
                per = $realtime - t0;
            end
        join
        check("flash_period", per >= 19.996 && per <= 100.0, 1);
        expect_rx(3, 8'h5a);
        check("flash_sent", f_got, 8'ha7);
        check("flash_falls", f_falls, 24);
        check("flash_oe", oe_or, 4'h1);
    endtask
    task automatic t_power();
        // nibble mode asked on the power link must fall back to single bits
        p_resp = 8'hc3;
        frame(1'b1, 1'b1, 1'b1, 2, 8'h3c);
        expect_rx(2, 8'hc3);
        check("pwr_sent", p_got, 8'h3d);
        check("pwr_falls", p_falls, 16);
        check("flash_quiet", oe_or, 4'h0);
    endtask
    task automatic t_quad();
        f_resp = 8'h96;
        frame(1'b0, 1'b1, 1'b1, 2, 8'h00);
        expect_rx(2, 8'h96);
        check("quad_read_oe", oe_or, 4'h0);
        check("quad_read_falls", f_falls, 4);
        frame(1'b0, 1'b1, 1'b0, 1, 8'hf0);
        check("quad_write_oe", oe_or, 4'hf);
        check("quad_write_falls", f_falls, 2);
        check("quad_write_sent", f_got, 8'hf0);
    endtask
    task automatic t_stall();
        f_resp = 8'h11;
        @(posedge clk);
        rx_ready <= 1'b0;
        fork
            frame(1'b0, 1'b0, 1'b0, 3, 8'h81);
            begin
                repeat (400) @(negedge clk);
                check("parked", {busy, fsel_n, fclk, rx_valid}, 4'h9);
                check("nothing_taken", rxq.size(), 0);
                @(posedge clk);
                rx_ready <= 1'b1;
            end
        join
        expect_rx(3, 8'h11);
        check("stall_sent", f_got, 8'h83);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #(60000 * 5);
        miscompares++;
        end_of_test();
    end
    initial begin
        nrst = 1'b0;
        cmd_valid = 1'b0;
        cmd_link = 1'b0;
        cmd_quad = 1'b0;
        cmd_qin = 1'b0;
        cmd_last = 1'b0;
        cmd_data = 8'h00;
        rx_ready = 1'b0;
        f_resp = 8'h00;
        p_resp = 8'h00;
        oe_or = 4'h0;
        t_reset();
        t_flash();
        t_power();
        t_quad();
        t_stall();
        check("clock_idle_low", idle_bad, 0);
        check("launch_on_fall", edge_bad, 0);
        end_of_test();
    end
endmodule
`default_nettype wire
